/* hdl/udb_baud_timer.sv */
// prescaler and 8-bit reloading baud timer, one pulse per overflow
`timescale 1ns/1ps
module udb_baud_timer (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [1:0] timer_prescale_select,
  input  wire logic       timer_one_clock_select,
  input  wire logic       external_clock_input,
  input  wire logic [7:0] timer_reload_value,
  output logic            overflow_pulse
);
  logic [5:0] pre_cnt_r;   // system clock prescaler
  logic [5:0] pre_last;    // last count for the chosen divide
  logic       ext_prev_r;  // previous external clock level
  logic [2:0] ext_cnt_r;   // external rising edge counter
  logic       ext_rise;    // external clock rising edge
  logic       pre_tick;    // prescaler output pulse
  logic       tmr_tick;    // timer count enable
  logic [7:0] tmr_cnt_r;   // baud timer count

  // choose the divide for the system clock prescaler
  always_comb begin
    case (timer_prescale_select)
      udb_pkg::PRESCALE_DIV12: pre_last = udb_pkg::DIV12_LAST;
      udb_pkg::PRESCALE_DIV4:  pre_last = udb_pkg::DIV4_LAST;
      udb_pkg::PRESCALE_DIV48: pre_last = udb_pkg::DIV48_LAST;
      default:                 pre_last = udb_pkg::DIV48_LAST;
    endcase
  end

  assign ext_rise = external_clock_input & ~ext_prev_r;
  // prescaler pulse: system clock divides, or every eighth external edge
  assign pre_tick = (timer_prescale_select == udb_pkg::PRESCALE_EXT8)
                    ? (ext_rise && ext_cnt_r == udb_pkg::EXT8_LAST)
                    : (pre_cnt_r == pre_last);
  // direct system clock overrides the prescaler
  assign tmr_tick = timer_one_clock_select | pre_tick;

  // system clock prescaler counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_r <= '0;
    end else if (pre_cnt_r >= pre_last) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 6'd1;
    end
  end

  // external clock edge counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev_r <= 1'b0;
      ext_cnt_r  <= '0;
    end else begin
      ext_prev_r <= external_clock_input;
      if (ext_rise) begin
        ext_cnt_r <= ext_cnt_r + 3'd1;
      end
    end
  end

  // reloading timer; overflow pulse is registered
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_cnt_r      <= udb_pkg::TIMER_RST;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= 1'b0;
      if (tmr_tick) begin
        if (tmr_cnt_r == udb_pkg::TIMER_TOP) begin
          tmr_cnt_r      <= timer_reload_value;
          overflow_pulse <= 1'b1;
        end else begin
          tmr_cnt_r <= tmr_cnt_r + 8'd1;
        end
      end
    end
  end

  // timer counts every cycle when fed directly
  property p_direct_clock;
    @(posedge mclk) disable iff (!arst_n)
    timer_one_clock_select && tmr_cnt_r != udb_pkg::TIMER_TOP
      |=> tmr_cnt_r == $past(tmr_cnt_r) + 8'd1;
  endproperty
  a_direct_clock: assert property (p_direct_clock) else $error("timer missed a direct tick");

  // divide by four spaces prescaler pulses four cycles apart
  property p_div4;
    @(posedge mclk) disable iff (!arst_n)
    (timer_prescale_select == udb_pkg::PRESCALE_DIV4)[*5] ##0 pre_tick
      |=> !pre_tick ##1 !pre_tick ##1 !pre_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

  // overflow reloads the timer with the reload value
  property p_reload;
    @(posedge mclk) disable iff (!arst_n)
    tmr_tick && tmr_cnt_r == udb_pkg::TIMER_TOP
      |=> overflow_pulse && tmr_cnt_r == $past(timer_reload_value);
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload");

  c_ext8: cover property (@(posedge mclk) disable iff (!arst_n)
    timer_prescale_select == udb_pkg::PRESCALE_EXT8 && overflow_pulse);
endmodule // udb_baud_timer

/* hdl/udb_serial_buffer.sv */
// serial data buffer: transmit shifter, receive latch, flags, baud timing
//
// Behaviour
// - one address maps to transmit and receive
// - buffer write loads shifter and starts frame
// - buffer read returns receive latch only
// - eight bits, bit 7 most significant
// - prescale select picks 12, 4, 48, external/8
// - clock select bit bypasses the prescaler
// - transmit flag at stop bit, software clears
// - receive flag at stop sampling, software clears
// - receive only while receive enable set
`timescale 1ns/1ps
module udb_serial_buffer (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [3:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic [1:0] timer_prescale_select,
  input  wire logic       timer_one_clock_select,
  input  wire logic       external_clock_input,
  input  wire logic [7:0] timer_reload_value,
  input  wire logic       frame_length_select,
  input  wire logic       tx_ninth_bit,
  input  wire logic       receive_enable_bit,
  input  wire logic       transmit_flag_clear,
  input  wire logic       receive_flag_clear,
  input  wire logic       rx_line,
  output logic            tx_line,
  output logic            transmit_complete_flag,
  output logic            receive_complete_flag,
  output logic            rx_ninth_bit
);
  typedef enum logic [2:0] {UDB_IDLE, UDB_START, UDB_DATA, UDB_NINTH, UDB_STOP} udb_state_t;

  logic       ovf;            // baud timer overflow pulse
  logic       buf_hit;        // access decodes to the data buffer
  logic       buf_wr;         // software write to the buffer
  logic       buf_rd;         // software read of the buffer
  udb_state_t tx_state_r;     // transmit sequencer
  logic [7:0] tx_shift_r;     // transmit shift register
  logic [3:0] tx_idx_r;       // data bit index
  logic       tx_half_r;      // first of two overflows in a bit
  logic       tx_bit_end;     // end of a transmit bit time
  udb_state_t rx_state_r;     // receive sequencer
  logic [7:0] rx_shift_r;     // receive shift register
  logic [7:0] rx_latch_r;     // receive latch read by software
  logic [3:0] rx_idx_r;       // receive bit index
  logic       rx_half_r;      // first of two overflows in a bit
  logic       rx_prev_r;      // previous receive line level
  logic       rx_sample;      // sampling instant
  logic       tc_set;         // transmit flag set event
  logic       rc_set;         // receive flag set event

  udb_baud_timer u_baud (
    .mclk                   (mclk),
    .arst_n                 (arst_n),
    .timer_prescale_select  (timer_prescale_select),
    .timer_one_clock_select (timer_one_clock_select),
    .external_clock_input   (external_clock_input),
    .timer_reload_value     (timer_reload_value),
    .overflow_pulse         (ovf)
  );

  // one address, two storage elements
  assign buf_hit    = sfr_page == udb_pkg::SFR_PAGE_ZERO
                      && sfr_addr == udb_pkg::SERIAL_DATA_BUFFER_ADDR;
  assign buf_wr     = buf_hit && sfr_wr;
  assign buf_rd     = buf_hit && sfr_rd;
  assign tx_bit_end = ovf && tx_half_r;   // two overflows per bit
  assign rx_sample  = ovf && rx_half_r;
  // transmit flag: leaving last data bit (8-bit) or ninth bit (9-bit)
  assign tc_set = tx_bit_end && ((tx_state_r == UDB_DATA && tx_idx_r == udb_pkg::DATA_BITS_LAST
                  && !frame_length_select) || tx_state_r == UDB_NINTH);
  assign rc_set = rx_state_r == UDB_STOP && rx_sample;

  // read data: receive latch on a buffer read, zero otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= udb_pkg::SERIAL_DATA_BUFFER_RST;
    end else begin
      sfr_rdata <= buf_rd ? rx_latch_r : 8'h00;
    end
  end

  // transmit sequencer; a write restarts a frame at once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_r <= UDB_IDLE;
      tx_shift_r <= udb_pkg::SERIAL_DATA_BUFFER_RST;
      tx_idx_r   <= '0;
      tx_half_r  <= 1'b0;
      tx_line    <= 1'b1;
    end else if (buf_wr) begin
      tx_shift_r <= sfr_wdata;
      tx_state_r <= UDB_START;
      tx_idx_r   <= '0;
      tx_half_r  <= 1'b0;
      tx_line    <= 1'b0;      // start bit goes out now
    end else begin
      if (ovf) begin
        tx_half_r <= ~tx_half_r;
      end
      if (tx_bit_end) begin
        case (tx_state_r)
          UDB_START: begin
            tx_state_r <= UDB_DATA;
            tx_line    <= tx_shift_r[0];
          end
          UDB_DATA: begin
            if (tx_idx_r == udb_pkg::DATA_BITS_LAST) begin
              tx_state_r <= frame_length_select ? UDB_NINTH : UDB_STOP;
              tx_line    <= frame_length_select ? tx_ninth_bit : 1'b1;
            end else begin
              tx_line <= tx_shift_r[1];
            end
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_idx_r   <= tx_idx_r + 4'd1;
          end
          UDB_NINTH: begin
            tx_state_r <= UDB_STOP;
            tx_line    <= 1'b1;
          end
          UDB_STOP: tx_state_r <= UDB_IDLE;
          default:  tx_state_r <= UDB_IDLE;
        endcase
      end
    end
  end

  // receive sequencer: start on falling edge, sample mid-bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_r   <= UDB_IDLE;
      rx_shift_r   <= '0;
      rx_latch_r   <= udb_pkg::SERIAL_DATA_BUFFER_RST;
      rx_idx_r     <= '0;
      rx_half_r    <= 1'b0;
      rx_prev_r    <= 1'b1;
      rx_ninth_bit <= 1'b0;
    end else begin
      rx_prev_r <= rx_line;
      if (!receive_enable_bit) begin
        rx_state_r <= UDB_IDLE;
      end else begin
        if (ovf) begin
          rx_half_r <= ~rx_half_r;
        end
        case (rx_state_r)
          UDB_IDLE: begin
            if (rx_prev_r && !rx_line) begin
              rx_state_r <= UDB_START;
              rx_half_r  <= 1'b1;  // first overflow lands near mid-bit
            end
          end
          UDB_START: begin
            if (rx_sample) begin
              rx_state_r <= rx_line ? UDB_IDLE : UDB_DATA; // drop false starts
              rx_idx_r   <= '0;
            end
          end
          UDB_DATA: begin
            if (rx_sample) begin
              rx_shift_r <= {rx_line, rx_shift_r[7:1]};
              rx_idx_r   <= rx_idx_r + 4'd1;
              if (rx_idx_r == udb_pkg::DATA_BITS_LAST) begin
                rx_state_r <= frame_length_select ? UDB_NINTH : UDB_STOP;
              end
            end
          end
          UDB_NINTH: begin
            if (rx_sample) begin
              rx_ninth_bit <= rx_line;
              rx_state_r   <= UDB_STOP;
            end
          end
          UDB_STOP: begin
            if (rx_sample) begin
              rx_latch_r <= rx_shift_r;
              if (!frame_length_select) begin
                rx_ninth_bit <= rx_line;  // stop level in 8-bit mode
              end
              rx_state_r <= UDB_IDLE;
            end
          end
          default: rx_state_r <= UDB_IDLE;
        endcase
      end
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_complete_flag <= 1'b0;
      receive_complete_flag  <= 1'b0;
    end else begin
      if (tc_set) begin
        transmit_complete_flag <= 1'b1;
      end else if (transmit_flag_clear) begin
        transmit_complete_flag <= 1'b0;
      end
      if (rc_set && receive_enable_bit) begin
        receive_complete_flag <= 1'b1;
      end else if (receive_flag_clear) begin
        receive_complete_flag <= 1'b0;
      end
    end
  end

  // a read returns the receive latch, not the written byte
  property p_read_latch;
    @(posedge mclk) disable iff (!arst_n)
    buf_rd |=> sfr_rdata == $past(rx_latch_r);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("read did not return latch");

  // a write begins the start bit on the next cycle
  property p_write_starts;
    @(posedge mclk) disable iff (!arst_n)
    buf_wr |=> tx_state_r == UDB_START && !tx_line && tx_shift_r == $past(sfr_wdata);
  endproperty
  a_write_starts: assert property (p_write_starts) else $error("write did not start frame");

  // other addresses never start a frame
  property p_decode;
    @(posedge mclk) disable iff (!arst_n)
    sfr_wr && !buf_hit && tx_state_r == UDB_IDLE |=> tx_state_r == UDB_IDLE;
  endproperty
  a_decode: assert property (p_decode) else $error("foreign address started frame");

  // data leaves least significant bit first
  property p_lsb_first;
    @(posedge mclk) disable iff (!arst_n)
    tx_bit_end && tx_state_r == UDB_START && !buf_wr |=> tx_line == $past(tx_shift_r[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit wrong");

  // transmit flag rises only as the stop bit begins
  property p_tc_rise;
    @(posedge mclk) disable iff (!arst_n)
    $rose(transmit_complete_flag) |-> tx_state_r == UDB_STOP && tx_line;
  endproperty
  a_tc_rise: assert property (p_tc_rise) else $error("transmit flag set early");

  // receive flag rises with the latch update at stop sampling
  property p_rc_rise;
    @(posedge mclk) disable iff (!arst_n)
    $rose(receive_complete_flag) |-> $past(rc_set) && rx_state_r == UDB_IDLE;
  endproperty
  a_rc_rise: assert property (p_rc_rise) else $error("receive flag set without frame");

  // disabled receiver stays idle and never raises the flag
  property p_rx_disabled;
    @(posedge mclk) disable iff (!arst_n)
    !receive_enable_bit ##1 !receive_enable_bit
      |-> rx_state_r == UDB_IDLE && !$rose(receive_complete_flag);
  endproperty
  a_rx_disabled: assert property (p_rx_disabled) else $error("receiver active while off");

  c_tx_frame: cover property (@(posedge mclk) disable iff (!arst_n) tc_set);
  c_rx_frame: cover property (@(posedge mclk) disable iff (!arst_n) rc_set);
  c_nine_bit: cover property (@(posedge mclk) disable iff (!arst_n)
    frame_length_select && rx_state_r == UDB_NINTH);
  c_clear_race: cover property (@(posedge mclk) disable iff (!arst_n)
    tc_set && transmit_flag_clear);
endmodule // udb_serial_buffer

/* pkg/udb_pkg.sv */
// constants for the serial data buffer and its baud timer
package udb_pkg;
  localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;  // data buffer on page zero
  localparam logic [3:0] SFR_PAGE_ZERO           = 4'h0;   // page holding the buffer
  localparam logic [7:0] SERIAL_DATA_BUFFER_RST  = 8'h00;  // buffer reset value
  localparam logic [7:0] TIMER_RST               = 8'h00;  // timer count reset value
  localparam logic [1:0] PRESCALE_DIV12          = 2'h0;   // system clock / 12
  localparam logic [1:0] PRESCALE_DIV4           = 2'h1;   // system clock / 4
  localparam logic [1:0] PRESCALE_DIV48          = 2'h2;   // system clock / 48
  localparam logic [1:0] PRESCALE_EXT8           = 2'h3;   // external clock / 8
  localparam logic [5:0] DIV12_LAST              = 6'd11;  // last prescaler count, /12
  localparam logic [5:0] DIV4_LAST               = 6'd3;   // last prescaler count, /4
  localparam logic [5:0] DIV48_LAST              = 6'd47;  // last prescaler count, /48
  localparam logic [2:0] EXT8_LAST               = 3'd7;   // last external edge count, /8
  localparam logic [7:0] TIMER_TOP               = 8'hff;  // count that overflows
  localparam logic [3:0] DATA_BITS_LAST          = 4'd7;   // index of the eighth data bit
endpackage

/* tb/uart_data_buffer_baud_bench.sv */
// self-checking bench for the serial data buffer and its baud timer
`timescale 1ns/1ps
module uart_data_buffer_baud_bench;
  localparam logic [7:0] ADR = udb_pkg::SERIAL_DATA_BUFFER_ADDR;  // buffer address
  localparam int         BT  = 8;  // bit time, direct clock, reload 0xfc
  logic       mclk = 1'b0, arst_n = 1'b0;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [1:0] timer_prescale_select = 2'h0;
  logic       timer_one_clock_select = 1'b1, external_clock_input = 1'b0;
  logic [7:0] timer_reload_value = 8'hfc;
  logic       frame_length_select = 1'b0, tx_ninth_bit = 1'b0, receive_enable_bit = 1'b1;
  logic       transmit_flag_clear = 1'b0, receive_flag_clear = 1'b0;
  logic       rx_line, tx_line, transmit_complete_flag, receive_complete_flag, rx_ninth_bit;
  logic [7:0] last = 8'h00;  // byte the receive latch should hold
  logic [31:0] rng = 32'h0000_0043;  // xorshift state
  int         n_mismatch = 0;
  int         cmp_count = 0;

  udb_serial_buffer uut (
    .mclk, .arst_n, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .timer_prescale_select, .timer_one_clock_select, .external_clock_input,
    .timer_reload_value, .frame_length_select, .tx_ninth_bit, .receive_enable_bit,
    .transmit_flag_clear, .receive_flag_clear, .rx_line, .tx_line,
    .transmit_complete_flag, .receive_complete_flag, .rx_ninth_bit
  );
  udb_remote_uart remote (.mclk(mclk), .serial_out(rx_line));

  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  // external clock source: one rising edge every two clocks
  always @(posedge mclk) external_clock_input <= ~external_clock_input;

  // compare one value, count it, report a mismatch
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // xorshift random byte
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  // one register access; read data is sampled one cycle after the strobe edge
  task automatic bus(input logic wr, input logic [3:0] pg, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    sfr_page  <= pg;
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= wr;
    sfr_rd    <= ~wr;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask

  // pulse both flag clears for one cycle
  task automatic clr_flags();
    @(posedge mclk);
    transmit_flag_clear <= 1'b1;
    receive_flag_clear  <= 1'b1;
    @(posedge mclk);
    transmit_flag_clear <= 1'b0;
    receive_flag_clear  <= 1'b0;
    #1;
  endtask

  // write a byte, log the line until the flag rises, decode bits back from the flag
  task automatic tx_frame(input logic [7:0] d);
    logic       h[$];
    int         nb;
    logic [8:0] v;
    nb = frame_length_select ? 9 : 8;
    v  = 9'h000;
    bus(1'b1, 4'h0, ADR, d);
    while (transmit_complete_flag !== 1'b1 && h.size() < 12 * BT) begin
      h.push_back(tx_line);
      @(posedge mclk);
      #1;
    end
    for (int i = 0; i < nb; i++)
      v[i] = h[h.size() - (nb - i) * BT + BT / 2];
    check(v, frame_length_select ? {tx_ninth_bit, d} : {1'b0, d});
    repeat (BT / 2) @(posedge mclk);
    #1;
    check({transmit_complete_flag, tx_line}, 2'h3);
  endtask

  // a reception and a transmission side by side, then read back and clear
  task automatic duplex(input logic [7:0] rb, input logic [7:0] tb, input logic b8);
    fork
      remote.send(rb, frame_length_select, b8, BT);
      tx_frame(tb);
    join
    repeat (2 * BT) @(posedge mclk);
    #1;
    if (receive_enable_bit)
      last = rb;
    check(receive_complete_flag, receive_enable_bit);
    if (receive_enable_bit)
      check(rx_ninth_bit, frame_length_select ? b8 : 1'b1);
    bus(1'b0, 4'h0, ADR, 8'h00);
    check(sfr_rdata, last);
    @(posedge mclk);
    #1;
    check(sfr_rdata, 8'h00);
    clr_flags();
    check({transmit_complete_flag, receive_complete_flag}, 2'h0);
  endtask

  // set the timer, send 0x55 and time D0 start to D6 start: six bit times
  task automatic rate(input logic sel, input logic [1:0] ps, input logic [7:0] rl,
                      input int bt);
    int   c;
    int   n;
    logic p;
    @(posedge mclk);
    timer_one_clock_select <= sel;
    timer_prescale_select  <= ps;
    timer_reload_value     <= rl;
    repeat (bt + 600) @(posedge mclk);
    bus(1'b1, 4'h0, ADR, 8'h55);
    c = 0;
    while (tx_line !== 1'b1 && c < 3 * bt) begin
      @(posedge mclk);
      #1;
      c++;
    end
    c = 0;
    n = 0;
    p = 1'b1;
    while (n < 3 && c < 8 * bt) begin
      @(posedge mclk);
      #1;
      c++;
      if (tx_line === 1'b1 && p === 1'b0)
        n++;
      p = tx_line;
    end
    check(c[15:0], 16'(6 * bt));
  endtask

  // print the verdict and stop
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    check({tx_line, transmit_complete_flag, receive_complete_flag, rx_ninth_bit}, 4'h8);
    bus(1'b0, 4'h0, ADR, 8'h00);
    check(sfr_rdata, udb_pkg::SERIAL_DATA_BUFFER_RST);
    // the timer climbs from its reset count to its first reload before any frame
    repeat (300) @(posedge mclk);
    duplex(rnd(), rnd(), 1'b0);
    // other pages and addresses give no data and start no frame
    bus(1'b0, 4'h1, ADR, 8'h00);
    check(sfr_rdata, 8'h00);
    bus(1'b0, 4'h0, 8'h98, 8'h00);
    check(sfr_rdata, 8'h00);
    bus(1'b1, 4'h1, ADR, 8'h5a);
    bus(1'b1, 4'h0, 8'h9a, 8'h5a);
    repeat (3 * BT) @(posedge mclk);
    #1;
    check({tx_line, transmit_complete_flag}, 2'h2);
    // reception switched off: frame ignored, latch keeps its byte
    @(posedge mclk) receive_enable_bit <= 1'b0;
    duplex(rnd(), rnd(), 1'b0);
    @(posedge mclk) receive_enable_bit <= 1'b1;
    // a write in mid-frame restarts with the new byte
    bus(1'b1, 4'h0, ADR, 8'hc3);
    repeat (3 * BT) @(posedge mclk);
    duplex(rnd(), rnd(), 1'b1);
    // random traffic in both frame lengths
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      frame_length_select <= k[0];
      tx_ninth_bit        <= k[1];
      #1;
      duplex(rnd(), rnd(), ~k[1]);
    end
    rate(1'b1, 2'h2, 8'h96, 212);
    rate(1'b0, 2'h0, 8'ha0, 2304);
    rate(1'b0, 2'h1, 8'hff, 8);
    rate(1'b0, 2'h2, 8'hff, 96);
    rate(1'b0, 2'h3, 8'h70, 4608);
    give_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule // uart_data_buffer_baud_bench

/* tb/udb_remote_uart.sv */
// far-side serial sender that drives frames into the device receive input
`timescale 1ns/1ps
module udb_remote_uart (
  input  wire logic mclk,
  output logic      serial_out
);
  // the line idles high between frames
  initial serial_out = 1'b1;

  // start, data lsb first, optional ninth bit, stop; bt clocks per bit
  task automatic send(input logic [7:0] d, input logic nine, input logic b8, input int bt);
    logic [10:0] fr;
    fr = nine ? {1'b1, b8, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < 10 + int'(nine); i++) begin
      repeat (bt) @(posedge mclk) serial_out <= fr[i];
    end
    @(posedge mclk) serial_out <= 1'b1;
  endtask
endmodule // udb_remote_uart
